//--- common/cdio_pkg.sv
// Constants and types for the configurable digital I/O port
package cdio_pkg;
  localparam int          CDIO_NUM_PINS     = 7;
  localparam int          CDIO_CLK_MHZ      = 200;
  localparam int          CDIO_MIN_LOW_US   = 30;
  localparam int          CDIO_MIN_LOW_CYC  = CDIO_MIN_LOW_US * CDIO_CLK_MHZ;
  localparam int          CDIO_CNT_W        = 32;
  localparam int          CDIO_DUTY_W       = 32;
  localparam int          CDIO_FLT_W        = 14;
  localparam logic [1:0]  CDIO_MODE_DEFAULT = 2'h0;
  localparam logic [1:0]  CDIO_MODE_INPUT   = 2'h1;
  localparam logic [1:0]  CDIO_MODE_OUTPUT  = 2'h2;
  localparam logic [1:0]  CDIO_OUT_FALSE    = 2'h0;
  localparam logic [1:0]  CDIO_OUT_TRUE     = 2'h1;
  localparam logic [1:0]  CDIO_OUT_PWM      = 2'h2;
  localparam logic        CDIO_FAULT_ZERO   = 1'b0;
  localparam logic        CDIO_FAULT_OFF    = 1'b1;
  typedef enum logic [1:0] {CDIO_PHASE_LOW, CDIO_PHASE_HIGH} cdio_phase_t;
endpackage

//--- core/cdio_port.sv
// Seven-pin configurable digital I/O port core
// Summary of operation
// - Seven pins: default, input or output each
// - Output true drives low, false high
// - Invert flips the driven level
// - PWM from per-pin period and duty
// - Duty sets low fraction of period
// - Input reports sensed level, idle high one
// - Invert flips reported input sense
// - Pulses are active low, counted once low has held 30 us
// - Fault input zeros setpoint or switches off
// - Default mode hands pin to custom function
`timescale 1ns/1ps
`default_nettype none
module cdio_port
  import cdio_pkg::*;
(
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_n_in,
  input  wire logic                                 ce_in,
  input  wire logic [CDIO_NUM_PINS-1:0]             pin_in,
  output logic      [CDIO_NUM_PINS-1:0]             pin_out,
  output logic      [CDIO_NUM_PINS-1:0]             pin_oe_out,
  input  wire logic [2*CDIO_NUM_PINS-1:0]           mode_in,
  input  wire logic [2*CDIO_NUM_PINS-1:0]           out_sel_in,
  input  wire logic [CDIO_NUM_PINS-1:0]             invert_in,
  input  wire logic [CDIO_NUM_PINS*CDIO_CNT_W-1:0]  pwm_period_in,
  input  wire logic [CDIO_NUM_PINS*CDIO_DUTY_W-1:0] pwm_low_in,
  input  wire logic [CDIO_NUM_PINS-1:0]             custom_drive_in,
  input  wire logic [CDIO_NUM_PINS-1:0]             custom_oe_in,
  input  wire logic [CDIO_NUM_PINS-1:0]             fault_en_in,
  input  wire logic                                 fault_action_in,
  output logic      [CDIO_NUM_PINS-1:0]             input_value_out,
  output logic      [CDIO_NUM_PINS-1:0]             pulse_out,
  output logic      [CDIO_NUM_PINS-1:0]             custom_level_out,
  output logic                                      setpoint_zero_out,
  output logic                                      output_off_out
);
  logic                     rst_s1;
  logic                     rst_n;
  logic [CDIO_NUM_PINS-1:0] sync1;
  logic [CDIO_NUM_PINS-1:0] sync2;
  logic [CDIO_NUM_PINS-1:0] sync3;
  logic [CDIO_NUM_PINS-1:0] pwm_act;
  logic [CDIO_NUM_PINS-1:0] pulse_det;

  // Reset released through two flops to avoid metastable release
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Pins are asynchronous; idle reset value is high like an open pin
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end
    else if (ce_in)
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CDIO_NUM_PINS; g++)
    begin : gen_pin
      logic [1:0]            mode;
      logic [1:0]            osel;
      logic [CDIO_FLT_W-1:0] low_cnt;
      logic                  logical;
      assign mode = mode_in[2*g +: 2];
      assign osel = out_sel_in[2*g +: 2];

      cdio_pwm u_pwm (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n),
        .ce_in      (ce_in),
        .run_in     (mode == CDIO_MODE_OUTPUT && osel == CDIO_OUT_PWM),
        .period_in  (pwm_period_in[g*CDIO_CNT_W +: CDIO_CNT_W]),
        .low_cyc_in (pwm_low_in[g*CDIO_DUTY_W +: CDIO_DUTY_W]),
        .active_out (pwm_act[g])
      );

      always_comb
      begin
        unique case (osel)
          CDIO_OUT_TRUE:  logical = 1'b1;
          CDIO_OUT_PWM:   logical = pwm_act[g];
          default:        logical = 1'b0;
        endcase
      end

      // Logical true means low on the wire; invert swaps that
      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pin_out[g]    <= 1'b1;
          pin_oe_out[g] <= 1'b0;
        end
        else if (ce_in)
        begin
          unique case (mode)
            CDIO_MODE_OUTPUT:
            begin
              pin_out[g]    <= ~logical ^ invert_in[g];
              pin_oe_out[g] <= 1'b1;
            end
            CDIO_MODE_DEFAULT:
            begin
              pin_out[g]    <= custom_drive_in[g] ^ invert_in[g];
              pin_oe_out[g] <= custom_oe_in[g];
            end
            default:
            begin
              pin_out[g]    <= 1'b1;
              pin_oe_out[g] <= 1'b0;
            end
          endcase
        end
      end

      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          input_value_out[g]  <= 1'b1;
          custom_level_out[g] <= 1'b1;
        end
        else if (ce_in)
        begin
          if (mode == CDIO_MODE_INPUT)
            input_value_out[g] <= sync2[g] ^ invert_in[g];
          custom_level_out[g] <= sync2[g] ^ invert_in[g];
        end
      end

      // A pulse counts after the low level has stood the least low time
      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          low_cnt      <= '0;
          pulse_det[g] <= 1'b0;
        end
        else if (ce_in)
        begin
          pulse_det[g] <= 1'b0;
          if ((sync2[g] ^ invert_in[g]) == 1'b1)
            low_cnt <= '0;
          else if (low_cnt != CDIO_FLT_W'(CDIO_MIN_LOW_CYC))
          begin
            low_cnt <= low_cnt + 14'h1;
            if (low_cnt == CDIO_FLT_W'(CDIO_MIN_LOW_CYC - 1))
              pulse_det[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      pulse_out <= '0;
    else if (ce_in)
      pulse_out <= pulse_det;
  end

  // Fault latches until reset; clearing protection is the host's job
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setpoint_zero_out <= 1'b0;
      output_off_out    <= 1'b0;
    end
    else if (ce_in && |(pulse_det & fault_en_in))
    begin
      if (fault_action_in == CDIO_FAULT_OFF)
        output_off_out <= 1'b1;
      else
        setpoint_zero_out <= 1'b1;
    end
  end

  out_level_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && mode_in[1:0] == CDIO_MODE_OUTPUT && out_sel_in[1:0] == CDIO_OUT_TRUE)
    |=> (pin_out[0] == invert_in[0] || $changed(invert_in[0])))
    else $error("true output level wrong");
  out_oe_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && mode_in[1:0] == CDIO_MODE_OUTPUT) |=> pin_oe_out[0])
    else $error("output pin not driven");
  in_oe_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && mode_in[1:0] == CDIO_MODE_INPUT) |=> !pin_oe_out[0])
    else $error("input pin driven");
  // Invert may change on the next cycle, so compare with the sampled pair
  in_value_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && mode_in[1:0] == CDIO_MODE_INPUT)
    |=> input_value_out[0] == $past(sync2[0] ^ invert_in[0]))
    else $error("input value wrong");
  sync_delay_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in |=> sync2 == $past(sync1))
    else $error("sync chain broken");
  pulse_len_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(pulse_det[0]) |-> $past(sync3[0] ^ invert_in[0]) == 1'b0)
    else $error("pulse on high level");
  fault_off_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && |(pulse_det & fault_en_in) && fault_action_in == CDIO_FAULT_OFF)
    |=> output_off_out)
    else $error("fault did not switch off");
  fault_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && |(pulse_det & fault_en_in) && fault_action_in == CDIO_FAULT_ZERO)
    |=> setpoint_zero_out)
    else $error("fault did not zero setpoint");
  // A low clock enable legally holds the pulse, so only check running cycles
  pulse_one_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (pulse_out[0] && ce_in) |=> !pulse_out[0])
    else $error("pulse longer than one cycle");
endmodule
`default_nettype wire

//--- core/cdio_pwm.sv
// PWM generator for one pin: low for the duty count, high for the rest
`timescale 1ns/1ps
`default_nettype none
module cdio_pwm
  import cdio_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   ce_in,
  input  wire logic                   run_in,
  input  wire logic [CDIO_CNT_W-1:0]  period_in,
  input  wire logic [CDIO_DUTY_W-1:0] low_cyc_in,
  output var  logic                   active_out
);
  logic [CDIO_CNT_W-1:0] count;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count <= '0;
    else if (ce_in)
    begin
      if (!run_in || count + 32'h1 >= period_in)
        count <= '0;
      else
        count <= count + 32'h1;
    end
  end
  // Logical true (drive low) for the first low_cyc cycles of each period
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      active_out <= 1'b0;
    else if (ce_in)
      active_out <= run_in && (count < low_cyc_in);
  end
  pwm_low_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && run_in && $past(run_in) && count < low_cyc_in) |=> active_out)
    else $error("pwm active phase wrong");
endmodule
`default_nettype wire

//--- verif/cdio_ext_model.sv
// External unit model on the seven pins
`timescale 1ns/1ps
`default_nettype none
module cdio_ext_model
  import cdio_pkg::*;
(
  input  wire logic [CDIO_NUM_PINS-1:0] drive_in,
  input  wire logic [CDIO_NUM_PINS-1:0] drive_oe_in,
  input  wire logic [CDIO_NUM_PINS-1:0] pull_low_in,
  output logic      [CDIO_NUM_PINS-1:0] level_out
);
  // Pull-up: an open pin reads high, a pulse only pulls low
  // Low time is chosen by the bench, long or short on purpose
  always_comb
  begin
    for (int g = 0; g < CDIO_NUM_PINS; g++)
    begin
      level_out[g] = drive_oe_in[g] ? drive_in[g] : !pull_low_in[g];
    end
  end
endmodule
`default_nettype wire

//--- verif/cdio_port_tb.sv
// Self-checking bench for the digital I/O port
`timescale 1ns/1ps
`default_nettype none
module cdio_port_tb
  import cdio_pkg::*;
;
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic         fault_action = 1'b0;
  logic         ce = 1'b1;
  logic         sp_zero, out_off;
  logic [6:0]   pin_in, pin_out, pin_oe_out, ivo, pulse, clvl;
  logic [6:0]   invert = 7'h00;
  logic [6:0]   ext_low = 7'h00;
  logic [13:0]  mode = 14'h0000;
  logic [13:0]  out_sel = 14'h0000;
  int           err_total = 0;
  int           n_compared = 0;
  int           n_pulse = 0;
  int           lows;

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (pulse[1] === 1'b1) n_pulse++;

  cdio_ext_model cdio_ext_model_inst (.drive_in(pin_out), .drive_oe_in(pin_oe_out),
    .pull_low_in(ext_low), .level_out(pin_in));
  cdio_port cdio_port_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .mode_in(mode),
    .out_sel_in(out_sel), .invert_in(invert), .pwm_period_in({7{32'h0000000A}}),
    .pwm_low_in({7{32'h00000003}}), .custom_drive_in(7'h55), .custom_oe_in(7'h3C),
    .fault_en_in(7'h02), .fault_action_in(fault_action), .input_value_out(ivo),
    .pulse_out(pulse), .custom_level_out(clvl), .setpoint_zero_out(sp_zero),
    .output_off_out(out_off));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic results();
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cfg(input logic [13:0] m, input logic [13:0] s, input logic [6:0] inv);
    @(posedge clk_in);
    mode <= m;
    out_sel <= s;
    invert <= inv;
    wt(4);
  endtask

  // Pin 1 held low for about n cycles, input level seen meanwhile
  task automatic hold_low(input int n);
    @(posedge clk_in);
    ext_low <= 7'h02;
    wt(5);
    chk(ivo, 7'h7D);
    chk(clvl, 7'h7D);
    repeat (n - 6) @(posedge clk_in);
    ext_low <= 7'h00;
    wt(8);
  endtask

  // Low samples of pin 0 over one ten-cycle period
  task automatic pwm_lows(output int c);
    c = 0;
    wt(20);
    for (int i = 0; i < 10; i++)
    begin
      wt(0);
      c += (pin_out[0] === 1'b0) ? 1 : 0;
    end
  endtask

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wt(0);
    chk(pin_oe_out, 7'h00);
    chk(ivo, 7'h7F);
    wt(3);
    cfg(14'h2AAA, 14'h1555, 7'h00);
    chk(pin_out, 7'h00);
    chk(pin_oe_out, 7'h7F);
    // Clock enable low must freeze the driven levels
    @(posedge clk_in);
    ce <= 1'b0;
    cfg(14'h2AAA, 14'h0000, 7'h00);
    chk(pin_out, 7'h00);
    @(posedge clk_in);
    ce <= 1'b1;
    wt(4);
    chk(pin_out, 7'h7F);
    cfg(14'h2AAA, 14'h1555, 7'h7F);
    chk(pin_out, 7'h7F);
    cfg(14'h2AAA, 14'h0000, 7'h00);
    chk(pin_out, 7'h7F);
    cfg(14'h2AAA, 14'h3FFF, 7'h00);
    chk(pin_out, 7'h7F);
    cfg(14'h2AAA, 14'h0000, 7'h7F);
    chk(pin_out, 7'h00);
    cfg(14'h2AAA, 14'h2AAA, 7'h00);
    pwm_lows(lows);
    chk(lows, 3);
    cfg(14'h2AAA, 14'h2AAA, 7'h01);
    pwm_lows(lows);
    chk(lows, 7);
    cfg(14'h0000, 14'h0000, 7'h00);
    chk(pin_out & 7'h3C, 7'h14);
    chk(pin_oe_out, 7'h3C);
    chk(clvl, 7'h57);
    cfg(14'h3FFF, 14'h3FFF, 7'h00);
    chk(pin_oe_out, 7'h00);
    chk(pin_out, 7'h7F);
    cfg(14'h1555, 14'h0000, 7'h7F);
    chk(ivo, 7'h00);
    chk(clvl, 7'h00);
    cfg(14'h1555, 14'h0000, 7'h00);
    chk(pin_oe_out, 7'h00);
    chk(ivo, 7'h7F);
    chk(clvl, 7'h7F);
    hold_low(100);
    chk(n_pulse, 0);
    chk({sp_zero, out_off}, 2'h0);
    hold_low(6100);
    chk(n_pulse, 1);
    chk({sp_zero, out_off}, 2'h2);
    @(posedge clk_in);
    fault_action <= 1'b1;
    hold_low(6100);
    chk(n_pulse, 2);
    chk({sp_zero, out_off}, 2'h3);
    results();
  end

  // Run needs about 13000 cycles; three times that is a hang
  initial
  begin
    #200000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
